// *** bench/mps_port_tb.sv ***
// Bench for mps_port: random beats on all four channels against queue models.
// Assumes mps_pkg and the user model are compiled first.
`timescale 1ns/1ps
`include "mps_params.svh"
module message_port_stream_channels_tb_top
	import mps_pkg::*;
;
	logic core_clk, rst_n, msg_over_io, id_8bit, fill, go;
	logic [3:0] sv = 4'h0;
	logic [3:0] first_q = 4'hF;
	logic [3:0] acc = 4'h0;
	logic [1:0] lr = 2'h0;
	logic [1:0] mode;
	logic [31:0] rs = 32'hDFDAACAD;
	wire [3:0] sr, kv, kr;
	wire iresp_rdy, treq_rdy;
	wire msg_port_on;
	mps_beat_t sb [4] = '{default: '0};
	wire mps_beat_t kb [4];
	mps_beat_t exp_q [4][$];
	int n_fail, cmp_count, cnt [4];
	assign kr = {lr[1], treq_rdy, iresp_rdy, lr[0]};
	mps_port dut (.core_clk(core_clk), .rst_n(rst_n), .msg_over_io(msg_over_io),
		.id_8bit(id_8bit), .msg_port_on(msg_port_on),
		.s_axis_msgireq_tvalid(sv[0]), .s_axis_msgireq_tready(sr[0]),
		.s_axis_msgireq_tdata(sb[0].data), .s_axis_msgireq_tkeep(sb[0].keep),
		.s_axis_msgireq_tlast(sb[0].last), .s_axis_msgireq_tuser(sb[0].user),
		.link_ireq_valid(kv[0]), .link_ireq_ready(kr[0]), .link_ireq_beat(kb[0]),
		.link_iresp_valid(sv[1]), .link_iresp_ready(sr[1]), .link_iresp_beat(sb[1]),
		.m_axis_msgiresp_tvalid(kv[1]), .m_axis_msgiresp_tready(kr[1]),
		.m_axis_msgiresp_tdata(kb[1].data), .m_axis_msgiresp_tkeep(kb[1].keep),
		.m_axis_msgiresp_tlast(kb[1].last), .m_axis_msgiresp_tuser(kb[1].user),
		.link_treq_valid(sv[2]), .link_treq_ready(sr[2]), .link_treq_beat(sb[2]),
		.m_axis_msgtreq_tvalid(kv[2]), .m_axis_msgtreq_tready(kr[2]),
		.m_axis_msgtreq_tdata(kb[2].data), .m_axis_msgtreq_tkeep(kb[2].keep),
		.m_axis_msgtreq_tlast(kb[2].last), .m_axis_msgtreq_tuser(kb[2].user),
		.s_axis_msgtresp_tvalid(sv[3]), .s_axis_msgtresp_tready(sr[3]),
		.s_axis_msgtresp_tdata(sb[3].data), .s_axis_msgtresp_tkeep(sb[3].keep),
		.s_axis_msgtresp_tlast(sb[3].last), .s_axis_msgtresp_tuser(sb[3].user),
		.link_tresp_valid(kv[3]), .link_tresp_ready(kr[3]), .link_tresp_beat(kb[3]));
	mps_user_model partner (.core_clk(core_clk), .rst_n(rst_n), .mode(mode), .rbit(rs[5:4]),
		.iresp_tready(iresp_rdy), .treq_tready(treq_rdy));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic mps_beat_t fmt(input mps_beat_t b, input logic first);
		fmt = b;
		fmt.user = !first ? 32'h0 : (id_8bit ? b.user & 32'h00FF00FF : b.user);
	endfunction
	function automatic int pend();
		return exp_q[0].size() + exp_q[1].size() + exp_q[2].size() + exp_q[3].size();
	endfunction
	task automatic cmp_beat(input mps_beat_t got, input mps_beat_t exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected beat at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected flag at %0t: got %b", $time, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic drain(input string name);
		go <= 1'h0;
		for (int i = 0; i < 300 && (sv != 4'h0 || pend() != 0); i++)
			@(negedge core_clk);
		cmp_bit(pend() == 0, 1'h1);
		$display("test %s done", name);
	endtask
	initial begin
		core_clk = 1'h0;
		forever #2 core_clk = ~core_clk;
	end
	initial begin
		// Timeout at 5000 cycles, above the roughly 1800 cycles of tests with worst-case drains included
		#20000;
		n_fail++;
		tally_and_finish();
	end
	// Sources offer new beats only once the last one was taken
	always @(negedge core_clk) begin
		rs <= lfsr(rs);
		lr <= fill ? 2'h0 : (mode == 2'h0 ? 2'h3 : rs[7:6]);
		for (int c = 0; c < 4; c++)
			if (!sv[c] || acc[c]) begin
				sv[c] <= go & (fill | rs[c]);
				sb[c] <= '{data: {rs, rs + 32'(c)}, keep: `MPS_KEEP_ALL, last: rs[c + 8],
					user: {rs[15:0], rs[31:16]}};
			end
	end
	always @(posedge core_clk) begin
		acc <= sv & sr;
		for (int c = 0; c < 4; c++) begin
			if (sv[c] && sr[c] === 1'h1) begin
				exp_q[c].push_back(fmt(sb[c], first_q[c]));
				first_q[c] <= sb[c].last;
				cnt[c]++;
			end
			if (kv[c] === 1'h1 && kr[c])
				cmp_beat(kb[c], exp_q[c].pop_front());
		end
		if (!rst_n)
			first_q <= 4'hF;
	end
	initial begin
		rst_n = 1'h0;
		msg_over_io = 1'h0;
		id_8bit = 1'h0;
		mode = 2'h0;
		fill = 1'h0;
		go = 1'h0;
		n_fail = 0;
		cmp_count = 0;
		foreach (cnt[c]) cnt[c] = 0;
		repeat (12) @(negedge core_clk);
		rst_n = 1'h1;
		repeat (2) @(negedge core_clk);
		cmp_bit(msg_port_on, 1'h1);
		for (int t = 0; t < 2; t++) begin
			id_8bit <= t[0];
			mode <= 2'(t);
			go <= 1'h1;
			repeat (400) @(negedge core_clk);
			drain("traffic");
		end
		foreach (cnt[c]) cnt[c] = 0;
		fill <= 1'h1;
		mode <= 2'h2;
		go <= 1'h1;
		repeat (45) @(negedge core_clk);
		for (int c = 0; c < 4; c++) begin
			cmp_bit(cnt[c] == `MPS_FIFO_DEP, 1'h1);
			cmp_bit(sr[c], 1'h0);
		end
		fill <= 1'h0;
		mode <= 2'h1;
		drain("fill");
		msg_over_io <= 1'h1;
		rst_n <= 1'h0;
		repeat (12) @(negedge core_clk);
		rst_n <= 1'h1;
		go <= 1'h1;
		repeat (20) @(negedge core_clk);
		cmp_bit(msg_port_on, 1'h0);
		cmp_bit(|{sr, kv}, 1'h0);
		$display("test strap done");
		tally_and_finish();
	end
endmodule

// *** bench/mps_user_model.sv ***
// User logic that consumes the initiator response and target request streams.
// Assumes the bench supplies random bits and a pacing mode.
`timescale 1ns/1ps
module mps_user_model (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] mode,
	input  wire logic [1:0] rbit,
	output logic            iresp_tready,
	output logic            treq_tready
);
	// Mode 0 prompt, 1 random stalls, 2 full stall to fill the buffers
	always @(negedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			iresp_tready <= 1'h0;
			treq_tready  <= 1'h0;
		end else begin
			iresp_tready <= (mode == 2'h0) | ((mode == 2'h1) & rbit[0]);
			treq_tready  <= (mode == 2'h0) | ((mode == 2'h1) & rbit[1]);
		end
	end
endmodule

// *** hdl/mps_params.svh ***
// Constants for the message port stream channels.
// Assumes inclusion by the package, the design files of this block and the bench.
`ifndef MPS_PARAMS_SVH
`define MPS_PARAMS_SVH
`define MPS_DATA_W    64
`define MPS_KEEP_W    8
`define MPS_USER_W    32
`define MPS_KEEP_ALL  8'hFF
`define MPS_SRC_MSB   31
`define MPS_SRC_LSB   16
`define MPS_DST_MSB   15
`define MPS_DST_LSB   0
`define MPS_ID8_PAD   8'h00
`define MPS_FIFO_DEP  32
`define MPS_FIFO_AW   5
`endif

// *** hdl/mps_pkg.sv ***
// Types shared by the message port stream channels.
// Assumes mps_params.svh is on the include path.
`include "mps_params.svh"
package mps_pkg;
	typedef struct packed {
		logic [`MPS_DATA_W-1:0] data;
		logic [`MPS_KEEP_W-1:0] keep;
		logic                   last;
		logic [`MPS_USER_W-1:0] user;
	} mps_beat_t;
	typedef enum logic [1:0] {
		MPS_FIRST = 2'h0,
		MPS_BODY  = 2'h1
	} mps_pos_t;
endpackage

// *** hdl/mps_port.sv ***
// Message port stream channels: a buffered beat FIFO and the four-channel port.
// Assumes one clock core_clk, rst_n async active low, user logic on the stream side,
// and endpoint transport logic on the link side.
`timescale 1ns/1ps
`include "mps_params.svh"

////////////////////////////////////////////////////////////////////////////////
module mps_fifo #(
	parameter int WIDTH = 105,
	parameter int DEPTH = 32,
	parameter int AW    = 5
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;
	logic [WIDTH-1:0] out_q;
	logic             ov_q;
	logic             rdy_q;
	logic             cnt_empty;
	logic             pop;
	logic             push;
	logic             ov_d;
	logic [AW:0]      wr_d;
	logic [AW:0]      rd_d;
	logic [AW:0]      level;
	logic [AW:0]      level_d;
	logic             full_d;
	assign cnt_empty = (wr_q == rd_q);
	assign pop       = !cnt_empty && (!ov_q || out_ready);
	assign push      = in_valid && rdy_q;
	assign ov_d      = pop || (ov_q && !out_ready);
	assign wr_d      = wr_q + (AW+1)'(push);
	assign rd_d      = rd_q + (AW+1)'(pop);
	// Output stage counts toward depth, so DEPTH is the whole capacity
	assign level     = wr_q - rd_q + (AW+1)'(ov_q);
	assign level_d   = wr_d - rd_d + (AW+1)'(ov_d);
	assign full_d    = (level_d == (AW+1)'(DEPTH));
	assign in_ready  = rdy_q;
	assign out_valid = ov_q;
	assign out_data  = out_q;
	// Storage has no reset; pointers, flags and the output register get one
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data;
		end
	end
	// Ready registered from the next level, so it drops on the filling edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			ov_q  <= 1'b0;
			rdy_q <= 1'b0;
			out_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			ov_q  <= ov_d;
			rdy_q <= !full_d;
			if (pop) begin
				out_q <= mem_q[rd_q[AW-1:0]];
			end
		end
	end

	chk_hold_stable: assert property (@(posedge core_clk) disable iff (!rst_n)
		ov_q && !out_ready |=> ov_q && $stable(out_q)) else $error("fifo beat changed");
	chk_no_overfill: assert property (@(posedge core_clk) disable iff (!rst_n)
		level == (AW+1)'(DEPTH) |-> !in_ready) else $error("fifo ready while full");
	chk_level_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
		level <= (AW+1)'(DEPTH)) else $error("fifo holds more than its depth");
	chk_answer_next: assert property (@(posedge core_clk) disable iff (!rst_n)
		push && cnt_empty && !ov_q |-> ##2 out_valid) else $error("fifo output late");
endmodule

////////////////////////////////////////////////////////////////////////////////
module mps_port
	import mps_pkg::*;
(
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	input  wire logic                   msg_over_io,
	input  wire logic                   id_8bit,
	output logic                        msg_port_on,
	// Initiator request, user to endpoint
	input  wire logic                   s_axis_msgireq_tvalid,
	output logic                        s_axis_msgireq_tready,
	input  wire logic [`MPS_DATA_W-1:0] s_axis_msgireq_tdata,
	input  wire logic [`MPS_KEEP_W-1:0] s_axis_msgireq_tkeep,
	input  wire logic                   s_axis_msgireq_tlast,
	input  wire logic [`MPS_USER_W-1:0] s_axis_msgireq_tuser,
	output logic                        link_ireq_valid,
	input  wire logic                   link_ireq_ready,
	output mps_beat_t                   link_ireq_beat,
	// Initiator response, endpoint to user
	input  wire logic                   link_iresp_valid,
	output logic                        link_iresp_ready,
	input  wire mps_beat_t              link_iresp_beat,
	output logic                        m_axis_msgiresp_tvalid,
	input  wire logic                   m_axis_msgiresp_tready,
	output logic      [`MPS_DATA_W-1:0] m_axis_msgiresp_tdata,
	output logic      [`MPS_KEEP_W-1:0] m_axis_msgiresp_tkeep,
	output logic                        m_axis_msgiresp_tlast,
	output logic      [`MPS_USER_W-1:0] m_axis_msgiresp_tuser,
	// Target request, endpoint to user
	input  wire logic                   link_treq_valid,
	output logic                        link_treq_ready,
	input  wire mps_beat_t              link_treq_beat,
	output logic                        m_axis_msgtreq_tvalid,
	input  wire logic                   m_axis_msgtreq_tready,
	output logic      [`MPS_DATA_W-1:0] m_axis_msgtreq_tdata,
	output logic      [`MPS_KEEP_W-1:0] m_axis_msgtreq_tkeep,
	output logic                        m_axis_msgtreq_tlast,
	output logic      [`MPS_USER_W-1:0] m_axis_msgtreq_tuser,
	// Target response, user to endpoint
	input  wire logic                   s_axis_msgtresp_tvalid,
	output logic                        s_axis_msgtresp_tready,
	input  wire logic [`MPS_DATA_W-1:0] s_axis_msgtresp_tdata,
	input  wire logic [`MPS_KEEP_W-1:0] s_axis_msgtresp_tkeep,
	input  wire logic                   s_axis_msgtresp_tlast,
	input  wire logic [`MPS_USER_W-1:0] s_axis_msgtresp_tuser,
	output logic                        link_tresp_valid,
	input  wire logic                   link_tresp_ready,
	output mps_beat_t                   link_tresp_beat
);
	localparam int BW = $bits(mps_beat_t);

	// Forces qualifier to all ones; pads 8-bit IDs on first beat only
	function automatic mps_beat_t mps_fmt(input mps_beat_t b, input logic first,
			input logic narrow);
		mps_beat_t r;
		r      = b;
		r.keep = `MPS_KEEP_ALL;
		if (first && narrow) begin
			r.user[`MPS_SRC_MSB -: 8] = `MPS_ID8_PAD;
			r.user[`MPS_DST_MSB -: 8] = `MPS_ID8_PAD;
		end else if (!first) begin
			r.user = '0;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Strap caught after reset release so a mode change mid-packet cannot tear a frame
	logic en_q;
	logic strap_done_q;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_q         <= 1'b0;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			en_q         <= !msg_over_io;
			strap_done_q <= 1'b1;
		end
	end
	assign msg_port_on = en_q;

	////////////////////////////////////////////////////////////////////////////////
	// Per-channel packet position trackers: 0 ireq, 1 iresp, 2 treq, 3 tresp
	mps_pos_t  pos_q [4];
	logic      hs    [4];
	mps_beat_t src_b [4];
	mps_beat_t fmt_b [4];
	logic      in_v  [4];
	logic      in_r  [4];
	mps_beat_t out_b [4];
	logic      out_v [4];
	logic      out_r [4];

	assign src_b[0] = '{s_axis_msgireq_tdata, s_axis_msgireq_tkeep, s_axis_msgireq_tlast,
		s_axis_msgireq_tuser};
	assign src_b[1] = link_iresp_beat;
	assign src_b[2] = link_treq_beat;
	assign src_b[3] = '{s_axis_msgtresp_tdata, s_axis_msgtresp_tkeep, s_axis_msgtresp_tlast,
		s_axis_msgtresp_tuser};
	assign in_v[0] = s_axis_msgireq_tvalid && en_q;
	assign in_v[1] = link_iresp_valid && en_q;
	assign in_v[2] = link_treq_valid && en_q;
	assign in_v[3] = s_axis_msgtresp_tvalid && en_q;
	assign out_r[0] = link_ireq_ready;
	assign out_r[1] = m_axis_msgiresp_tready;
	assign out_r[2] = m_axis_msgtreq_tready;
	assign out_r[3] = link_tresp_ready;

	for (genvar i = 0; i < 4; i++) begin : g_ch
		assign hs[i]    = in_v[i] && in_r[i];
		assign fmt_b[i] = mps_fmt(src_b[i], pos_q[i] == MPS_FIRST, id_8bit);
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				pos_q[i] <= MPS_FIRST;
			end else if (hs[i]) begin
				pos_q[i] <= src_b[i].last ? MPS_FIRST : MPS_BODY;
			end
		end
		mps_fifo #(
			.WIDTH (BW),
			.DEPTH (`MPS_FIFO_DEP),
			.AW    (`MPS_FIFO_AW)
		) u_fifo (
			.core_clk  (core_clk),
			.rst_n     (rst_n),
			.in_valid  (in_v[i]),
			.in_ready  (in_r[i]),
			.in_data   (fmt_b[i]),
			.out_valid (out_v[i]),
			.out_ready (out_r[i]),
			.out_data  (out_b[i])
		);

		// Formatting and position checks on each channel, plus output quiet while omitted
		chk_keep_ones: assert property (@(posedge core_clk) disable iff (!rst_n)
			out_v[i] |-> out_b[i].keep == 8'hFF) else $error("qualifier not all ones");
		chk_body_user: assert property (@(posedge core_clk) disable iff (!rst_n)
			hs[i] && pos_q[i] == MPS_BODY |-> fmt_b[i].user == 32'h0)
			else $error("sideband leaked on body beat");
		chk_pad_ids: assert property (@(posedge core_clk) disable iff (!rst_n)
			hs[i] && pos_q[i] == MPS_FIRST && id_8bit |->
			fmt_b[i].user[31:24] == 8'h00 && fmt_b[i].user[15:8] == 8'h00 &&
			fmt_b[i].user[23:16] == src_b[i].user[23:16])
			else $error("8-bit id not padded");
		chk_first_user: assert property (@(posedge core_clk) disable iff (!rst_n)
			hs[i] && pos_q[i] == MPS_FIRST && !id_8bit |-> fmt_b[i].user == src_b[i].user)
			else $error("16-bit ids altered on first beat");
		chk_data_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
			hs[i] |-> fmt_b[i].data == src_b[i].data && fmt_b[i].last == src_b[i].last)
			else $error("data or last altered in formatting");
		chk_last_wraps: assert property (@(posedge core_clk) disable iff (!rst_n)
			hs[i] && src_b[i].last |=> pos_q[i] == MPS_FIRST)
			else $error("position not reset after last");
		chk_body_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
			hs[i] && !src_b[i].last |=> pos_q[i] == MPS_BODY)
			else $error("position not body after beat");
		chk_pos_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
			!hs[i] |=> $stable(pos_q[i])) else $error("position moved without a beat");
		chk_off_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
			strap_done_q && !en_q |-> !out_v[i]) else $error("channel output while omitted");
	end

	// Readies gate on the strap so an omitted port never takes a beat
	assign s_axis_msgireq_tready  = in_r[0] && en_q;
	assign link_iresp_ready       = in_r[1] && en_q;
	assign link_treq_ready        = in_r[2] && en_q;
	assign s_axis_msgtresp_tready = in_r[3] && en_q;

	// Outputs come straight from the buffer output registers
	assign link_ireq_valid        = out_v[0];
	assign link_ireq_beat         = out_b[0];
	assign m_axis_msgiresp_tvalid = out_v[1];
	assign m_axis_msgiresp_tdata  = out_b[1].data;
	assign m_axis_msgiresp_tkeep  = out_b[1].keep;
	assign m_axis_msgiresp_tlast  = out_b[1].last;
	assign m_axis_msgiresp_tuser  = out_b[1].user;
	assign m_axis_msgtreq_tvalid  = out_v[2];
	assign m_axis_msgtreq_tdata   = out_b[2].data;
	assign m_axis_msgtreq_tkeep   = out_b[2].keep;
	assign m_axis_msgtreq_tlast   = out_b[2].last;
	assign m_axis_msgtreq_tuser   = out_b[2].user;
	assign link_tresp_valid       = out_v[3];
	assign link_tresp_beat        = out_b[3];

	chk_off_blocks: assert property (@(posedge core_clk) disable iff (!rst_n)
		strap_done_q && !en_q |-> !s_axis_msgireq_tready && !s_axis_msgtresp_tready)
		else $error("port accepts while omitted");
	chk_ready_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		!en_q |-> !link_iresp_ready && !link_treq_ready)
		else $error("link accepted while omitted");
	chk_strap_once: assert property (@(posedge core_clk) disable iff (!rst_n)
		strap_done_q |=> $stable(en_q)) else $error("strap changed after capture");

	////////////////////////////////////////////////////////////////////////////////
	// Stalled beats must hold at every boundary, not only inside the buffers
	chk_ireq_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		link_ireq_valid && !link_ireq_ready |=> link_ireq_valid && $stable(link_ireq_beat))
		else $error("initiator request beat moved while stalled");
	chk_tresp_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		link_tresp_valid && !link_tresp_ready |=> link_tresp_valid && $stable(link_tresp_beat))
		else $error("target response beat moved while stalled");
	chk_iresp_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		m_axis_msgiresp_tvalid && !m_axis_msgiresp_tready |=> m_axis_msgiresp_tvalid &&
		$stable({m_axis_msgiresp_tdata, m_axis_msgiresp_tlast, m_axis_msgiresp_tuser}))
		else $error("initiator response beat moved while stalled");
	chk_treq_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		m_axis_msgtreq_tvalid && !m_axis_msgtreq_tready |=> m_axis_msgtreq_tvalid &&
		$stable({m_axis_msgtreq_tdata, m_axis_msgtreq_tlast, m_axis_msgtreq_tuser}))
		else $error("target request beat moved while stalled");
	chk_user_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!m_axis_msgiresp_tvalid || m_axis_msgiresp_tkeep == 8'hFF) &&
		(!m_axis_msgtreq_tvalid || m_axis_msgtreq_tkeep == 8'hFF))
		else $error("user qualifier not all ones");
	chk_link_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
		(!link_ireq_valid || link_ireq_beat.keep == 8'hFF) &&
		(!link_tresp_valid || link_tresp_beat.keep == 8'hFF))
		else $error("link qualifier not all ones");
endmodule
